/* hw/pas_app.sv */
/*
 * Application end: APB controller, transmit FIFO, substitute config space.
 * Assumes an APB master on pclk and pas_dev on the far side of pas_if.
 */
`include "pas_params.svh"
`default_nettype none
module pas_fifo #(
    parameter int W = 32,
    parameter int DEPTH = `PAS_FIFO_DEPTH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wp;
    logic [AW:0] rp;
    wire logic full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
    assign in_ready = !full;
    assign out_valid = (wp != rp);
    assign out_data = mem[rp[AW-1:0]];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp <= '0;
            rp <= '0;
        end else begin
            if (in_valid && in_ready) begin
                wp <= wp + 1'b1;
            end
            if (out_valid && out_ready) begin
                rp <= rp + 1'b1;
            end
        end
    end

    always_ff @(posedge pclk) begin
        if (in_valid && in_ready) begin
            mem[wp[AW-1:0]] <= in_data;
        end
    end
endmodule : pas_fifo

module pas_app #(
    parameter int MULTI_PKT = 1,
    parameter int PARITY_EN = 1,
    parameter int CFG_BYPASS = 0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    pas_if.app s
);
    // ==========================================
    // Bus decode
    wire logic acc = psel && penable;
    wire logic done = acc && pready;
    wire logic wr_done = done && pwrite;
    wire logic is_txd = (paddr == `PAS_REG_TXD);
    wire logic fifo_in_ready;
    wire logic fifo_out_valid;
    wire logic [31:0] fifo_out_data;
    // TXD writes stall in the access phase while the FIFO is full
    wire logic stall = pwrite && is_txd && !fifo_in_ready;

    logic [2:0] ctrl;
    logic txe;
    logic rxe;
    logic [31:0] rxd;
    logic [3:0] maddr;
    logic [31:0] mdata;
    pas_pkg::pas_mgmt_t mst;
    logic [2:0] wcnt;
    logic [31:0] sub_cfg [`PAS_CFG_WORDS];

    wire logic mapped = (paddr <= `PAS_REG_CONS) && (paddr[1:0] == 2'b00);
    wire logic [31:0] stat_w = {28'h0, mst != pas_pkg::PAS_M_IDLE, rxe, txe, s.reset_status};
    wire logic [31:0] rd_w =
        (paddr == `PAS_REG_CTRL) ? {29'h0, ctrl} :
        (paddr == `PAS_REG_STAT) ? stat_w :
        (paddr == `PAS_REG_CRED) ? {8'h00, s.cpl_hdr_cred, s.cpl_data_cred} :
        (paddr == `PAS_REG_MADDR) ? {28'h0, maddr} :
        (paddr == `PAS_REG_MDATA) ? mdata :
        (paddr == `PAS_REG_RXD) ? rxd :
        (paddr == `PAS_REG_CONS) ? {20'h0, s.cons_cred} : 32'h0;

    wire logic rx_beat = s.rx_valid && s.rx_ready;
    wire logic rx_perr = (PARITY_EN != 0) && (s.rx_par != pas_pkg::pas_par_f(s.rx_data));
    wire logic pop = fifo_out_valid && !s.tx_valid;
    wire logic tx_sent = s.tx_valid && s.tx_ready;
    wire logic [1:0] frame = (MULTI_PKT != 0) ? 2'b11 : 2'b01;
    wire logic [255:0] next_tx_data = {fifo_out_data, s.tx_data[255:32]};

    pas_fifo #(.W(32), .DEPTH(`PAS_FIFO_DEPTH)) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(wr_done && is_txd),
        .in_ready(fifo_in_ready),
        .in_data(pwdata),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_out_data)
    );

    // ==========================================
    // Register file
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
            ctrl <= 3'h0;
            txe <= 1'b0;
            rxe <= 1'b0;
            maddr <= 4'h0;
            mdata <= 32'h0;
        end else begin
            pready <= acc && !pready && !stall;
            pslverr <= acc && !pready && !stall && !mapped;
            prdata <= rd_w;
            if (wr_done && paddr == `PAS_REG_CTRL) begin
                ctrl <= pwdata[2:0];
            end
            if (wr_done && paddr == `PAS_REG_MADDR) begin
                maddr <= pwdata[3:0];
            end
            if (wr_done && paddr == `PAS_REG_MDATA) begin
                mdata <= pwdata;
            end else if (s.mgmt_ack && mst == pas_pkg::PAS_M_RD) begin
                mdata <= s.mgmt_dout;
            end
            // Sticky flags: set beats a same-cycle clear
            txe <= s.tx_err || (txe && !(wr_done && paddr == `PAS_REG_STAT && pwdata[`PAS_STAT_TXE]));
            rxe <= (rx_beat && rx_perr) || (rxe && !(wr_done && paddr == `PAS_REG_STAT && pwdata[`PAS_STAT_RXE]));
        end
    end

    assign s.alloc_sel = pas_pkg::pas_alloc_t'(ctrl[1:0]);
    assign s.cons_cred_sel = ctrl[`PAS_CTRL_SEL];

    // ==========================================
    // Management port sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mst <= pas_pkg::PAS_M_IDLE;
            s.mgmt_rden <= 1'b0;
            s.mgmt_wren <= 1'b0;
            s.mgmt_addr <= 4'h0;
            s.mgmt_din <= 32'h0;
        end else begin
            unique case (mst)
                pas_pkg::PAS_M_IDLE: begin
                    if (wr_done && paddr == `PAS_REG_MCMD && (pwdata[0] || pwdata[1])) begin
                        mst <= pwdata[1] ? pas_pkg::PAS_M_WR : pas_pkg::PAS_M_RD;
                        s.mgmt_wren <= pwdata[1];
                        s.mgmt_rden <= !pwdata[1];
                        s.mgmt_addr <= maddr;
                        s.mgmt_din <= mdata;
                    end
                end
                pas_pkg::PAS_M_RD, pas_pkg::PAS_M_WR: begin
                    if (s.mgmt_ack) begin
                        mst <= pas_pkg::PAS_M_IDLE;
                        s.mgmt_rden <= 1'b0;
                        s.mgmt_wren <= 1'b0;
                    end
                end
                default: mst <= pas_pkg::PAS_M_IDLE;
            endcase
        end
    end

    // ==========================================
    // Transmit gather, receive capture, substitute config space
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wcnt <= 3'h0;
            s.tx_valid <= 1'b0;
            s.tx_data <= 256'h0;
            s.tx_par <= 32'h0;
            s.tx_sop <= 2'b00;
            s.tx_eop <= 2'b00;
            s.rx_ready <= 1'b0;
            rxd <= 32'h0;
            s.cfg_rsp_valid <= 1'b0;
            s.cfg_rsp_data <= 32'h0;
            for (int i = 0; i < `PAS_CFG_WORDS; i++) begin
                sub_cfg[i] <= 32'h0;
            end
        end else begin
            s.rx_ready <= !s.reset_status;
            if (pop) begin
                s.tx_data <= next_tx_data;
                wcnt <= wcnt + 3'h1;
                if (wcnt == 3'h7) begin
                    s.tx_valid <= 1'b1;
                    s.tx_par <= (PARITY_EN != 0) ? pas_pkg::pas_par_f(next_tx_data) : 32'h0;
                    s.tx_sop <= frame;
                    s.tx_eop <= frame;
                end
            end else if (tx_sent) begin
                s.tx_valid <= 1'b0;
            end
            if (rx_beat) begin
                rxd <= s.rx_data[31:0];
            end
            s.cfg_rsp_valid <= s.cfg_req_valid && (CFG_BYPASS != 0);
            s.cfg_rsp_data <= sub_cfg[s.cfg_req_addr];
            if (s.cfg_req_valid && s.cfg_req_wr && CFG_BYPASS != 0) begin
                sub_cfg[s.cfg_req_addr] <= s.cfg_req_wdata;
            end
        end
    end
endmodule : pas_app
`default_nettype wire

/* hw/pas_dev.sv */
/*
 * Hard block end of the streaming application interface with its options.
 * Assumes the link side shares pclk and honours the ready flops.
 */
`include "pas_params.svh"
`default_nettype none
module pas_dev #(
    parameter int MULTI_PKT = 1,
    parameter int VF_VARIANT = 0,
    parameter int PARITY_EN = 1,
    parameter int RST_OUT_EN = 1,
    parameter int CONS_SEL_EN = 1,
    parameter int CFG_BYPASS = 0,
    parameter int MGMT_EN = 1,
    parameter int RST_HOLD = `PAS_RST_HOLD
) (
    input wire logic pclk,
    input wire logic presetn,
    pas_if.dev s,
    input wire logic link_rx_valid,
    output logic link_rx_ready,
    input wire logic [255:0] link_rx_data,
    input wire logic [1:0] link_rx_sop,
    input wire logic [1:0] link_rx_eop,
    output logic link_tx_valid,
    input wire logic link_tx_ready,
    output logic [255:0] link_tx_data,
    output logic [1:0] link_tx_sop,
    output logic [1:0] link_tx_eop,
    output logic link_tx_err,
    input wire logic link_cfg_valid,
    input wire logic link_cfg_wr,
    input wire logic [3:0] link_cfg_addr,
    input wire logic [31:0] link_cfg_wdata,
    output logic link_cfg_rsp_valid,
    output logic [31:0] link_cfg_rsp_data
);
    // ==========================================
    // Option decode
    localparam bit MPC = (MULTI_PKT != 0) && (VF_VARIANT == 0);
    localparam logic [11:0] DCRED = 12'((256 / 8) / `PAS_CRED_BYTES);

    // ==========================================
    // Credit split
    function automatic logic [23:0] cred_f(input pas_pkg::pas_alloc_t a);
        int rh;
        int rd;
        int rem;
        int ch;
        int cd;
        rh = `PAS_BAL_RH;
        rd = `PAS_BAL_RD;
        unique case (a)
            pas_pkg::PAS_ALLOC_MIN: begin
                rh = `PAS_MIN_RH;
                rd = `PAS_MIN_RD;
            end
            pas_pkg::PAS_ALLOC_LOW: begin
                rh = `PAS_LOW_RH;
                rd = `PAS_LOW_RD;
            end
            default: begin
                rh = `PAS_BAL_RH;
                rd = `PAS_BAL_RD;
            end
        endcase
        // Posted and non-posted get equal shares
        rem = `PAS_BUF_BYTES - 2 * (rh * `PAS_HDR_BYTES + rd * `PAS_DATA_BYTES);
        ch = rem / (`PAS_HDR_BYTES + `PAS_CPL_RATIO * `PAS_DATA_BYTES);
        cd = (rem - ch * `PAS_HDR_BYTES) / `PAS_DATA_BYTES;
        return {ch[11:0], cd[11:0]};
    endfunction : cred_f

    wire logic [23:0] cred_w = cred_f(s.alloc_sel);

    // ==========================================
    // Reset status
    logic [7:0] rst_cnt;
    wire logic rst_done = (rst_cnt == 8'(RST_HOLD));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_cnt <= 8'h00;
            s.reset_status <= 1'b1;
            s.stream_reset <= 1'b1;
            s.cpl_hdr_cred <= 12'h000;
            s.cpl_data_cred <= 12'h000;
        end else begin
            rst_cnt <= rst_done ? rst_cnt : rst_cnt + 8'h01;
            s.reset_status <= !rst_done;
            s.stream_reset <= (RST_OUT_EN != 0) && !rst_done;
            s.cpl_hdr_cred <= cred_w[23:12];
            s.cpl_data_cred <= cred_w[11:0];
        end
    end

    // ==========================================
    // Receive path
    wire logic rx_take = link_rx_valid && link_rx_ready;
    wire logic next_rx_v = rx_take || (s.rx_valid && !s.rx_ready);
    wire logic [1:0] rx_sop_w = MPC ? link_rx_sop : {1'b0, link_rx_sop[0]};
    wire logic [1:0] rx_eop_w = MPC ? link_rx_eop : {1'b0, link_rx_eop[0]};
    wire logic [31:0] rx_par_w = (PARITY_EN != 0) ? pas_pkg::pas_par_f(link_rx_data) : 32'h0;

    // One-entry stage: ready only while empty, trading rate for flop outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s.rx_valid <= 1'b0;
            link_rx_ready <= 1'b0;
            s.rx_data <= 256'h0;
            s.rx_par <= 32'h0;
            s.rx_sop <= 2'b00;
            s.rx_eop <= 2'b00;
        end else begin
            s.rx_valid <= next_rx_v;
            link_rx_ready <= !next_rx_v && rst_done;
            if (rx_take) begin
                s.rx_data <= link_rx_data;
                s.rx_par <= rx_par_w;
                s.rx_sop <= rx_sop_w;
                s.rx_eop <= rx_eop_w;
            end
        end
    end

    // ==========================================
    // Transmit path
    wire logic tx_take = s.tx_valid && s.tx_ready;
    wire logic next_tx_v = tx_take || (link_tx_valid && !link_tx_ready);
    wire logic tx_perr = (PARITY_EN != 0) && (s.tx_par != pas_pkg::pas_par_f(s.tx_data));
    wire logic tx_ferr = !MPC && (s.tx_sop[1] || s.tx_eop[1]);
    wire logic [1:0] tx_sop_w = MPC ? s.tx_sop : {1'b0, s.tx_sop[0]};
    wire logic [1:0] tx_eop_w = MPC ? s.tx_eop : {1'b0, s.tx_eop[0]};
    wire logic [11:0] hdr_inc = 12'(tx_sop_w[0]) + 12'(tx_sop_w[1]);

    logic [11:0] hdr_cons;
    logic [11:0] data_cons;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_tx_valid <= 1'b0;
            s.tx_ready <= 1'b0;
            link_tx_data <= 256'h0;
            link_tx_sop <= 2'b00;
            link_tx_eop <= 2'b00;
            link_tx_err <= 1'b0;
            s.tx_err <= 1'b0;
            hdr_cons <= 12'h000;
            data_cons <= 12'h000;
            s.cons_cred <= 12'h000;
        end else begin
            link_tx_valid <= next_tx_v;
            s.tx_ready <= !next_tx_v && rst_done;
            s.tx_err <= tx_take && (tx_perr || tx_ferr);
            if (tx_take) begin
                link_tx_data <= s.tx_data;
                link_tx_sop <= tx_sop_w;
                link_tx_eop <= tx_eop_w;
                link_tx_err <= tx_perr || tx_ferr;
                hdr_cons <= hdr_cons + hdr_inc;
                data_cons <= data_cons + DCRED;
            end
            s.cons_cred <= ((CONS_SEL_EN != 0) && s.cons_cred_sel) ? data_cons : hdr_cons;
        end
    end

    // ==========================================
    // Configuration space and management port
    logic [31:0] cfg_mem [`PAS_CFG_WORDS];
    wire logic link_int = link_cfg_valid && (CFG_BYPASS == 0);
    // Link requests win; the management port waits a cycle
    wire logic mgmt_go = (MGMT_EN != 0) && (s.mgmt_rden || s.mgmt_wren) && !s.mgmt_ack && !link_int;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `PAS_CFG_WORDS; i++) begin
                cfg_mem[i] <= 32'h0;
            end
            link_cfg_rsp_valid <= 1'b0;
            link_cfg_rsp_data <= 32'h0;
            s.cfg_req_valid <= 1'b0;
            s.cfg_req_wr <= 1'b0;
            s.cfg_req_addr <= 4'h0;
            s.cfg_req_wdata <= 32'h0;
            s.mgmt_ack <= 1'b0;
            s.mgmt_dout <= 32'h0;
        end else begin
            s.cfg_req_valid <= link_cfg_valid && (CFG_BYPASS != 0);
            s.cfg_req_wr <= link_cfg_wr;
            s.cfg_req_addr <= link_cfg_addr;
            s.cfg_req_wdata <= link_cfg_wdata;
            if (CFG_BYPASS != 0) begin
                link_cfg_rsp_valid <= s.cfg_rsp_valid;
                link_cfg_rsp_data <= s.cfg_rsp_data;
            end else begin
                link_cfg_rsp_valid <= link_cfg_valid;
                link_cfg_rsp_data <= cfg_mem[link_cfg_addr];
            end
            if (link_int && link_cfg_wr) begin
                cfg_mem[link_cfg_addr] <= link_cfg_wdata;
            end
            s.mgmt_ack <= mgmt_go;
            if (mgmt_go) begin
                s.mgmt_dout <= cfg_mem[s.mgmt_addr];
                if (s.mgmt_wren) begin
                    cfg_mem[s.mgmt_addr] <= s.mgmt_din;
                end
            end
        end
    end
endmodule : pas_dev
`default_nettype wire

/* inc/pas_if.sv */
/*
 * Link between the hard block end and the application end.
 * Assumes one clock shared by both ends; the bench joins them.
 */
`default_nettype none
interface pas_if;
    logic [255:0] rx_data;
    logic [31:0] rx_par;
    logic [1:0] rx_sop;
    logic [1:0] rx_eop;
    logic rx_valid;
    logic rx_ready;
    logic [255:0] tx_data;
    logic [31:0] tx_par;
    logic [1:0] tx_sop;
    logic [1:0] tx_eop;
    logic tx_valid;
    logic tx_ready;
    logic tx_err;
    logic reset_status;
    logic stream_reset;
    pas_pkg::pas_alloc_t alloc_sel;
    logic [11:0] cpl_hdr_cred;
    logic [11:0] cpl_data_cred;
    logic cons_cred_sel;
    logic [11:0] cons_cred;
    logic cfg_req_valid;
    logic cfg_req_wr;
    logic [3:0] cfg_req_addr;
    logic [31:0] cfg_req_wdata;
    logic cfg_rsp_valid;
    logic [31:0] cfg_rsp_data;
    logic mgmt_rden;
    logic mgmt_wren;
    logic [3:0] mgmt_addr;
    logic [31:0] mgmt_din;
    logic mgmt_ack;
    logic [31:0] mgmt_dout;

    modport dev (
        output rx_data, rx_par, rx_sop, rx_eop, rx_valid, tx_ready, tx_err,
        output reset_status, stream_reset, cpl_hdr_cred, cpl_data_cred, cons_cred,
        output cfg_req_valid, cfg_req_wr, cfg_req_addr, cfg_req_wdata, mgmt_ack, mgmt_dout,
        input rx_ready, tx_data, tx_par, tx_sop, tx_eop, tx_valid, alloc_sel, cons_cred_sel,
        input cfg_rsp_valid, cfg_rsp_data, mgmt_rden, mgmt_wren, mgmt_addr, mgmt_din
    );
    modport app (
        input rx_data, rx_par, rx_sop, rx_eop, rx_valid, tx_ready, tx_err,
        input reset_status, stream_reset, cpl_hdr_cred, cpl_data_cred, cons_cred,
        input cfg_req_valid, cfg_req_wr, cfg_req_addr, cfg_req_wdata, mgmt_ack, mgmt_dout,
        output rx_ready, tx_data, tx_par, tx_sop, tx_eop, tx_valid, alloc_sel, cons_cred_sel,
        output cfg_rsp_valid, cfg_rsp_data, mgmt_rden, mgmt_wren, mgmt_addr, mgmt_din
    );
endinterface : pas_if
`default_nettype wire

/* inc/pas_params.svh */
/*
 * Constants for the streaming application interface options block.
 * Assumes inclusion by bare name from inc/.
 */
`ifndef PAS_PARAMS_SVH
`define PAS_PARAMS_SVH

// ==========================================
// Receive buffer and credit sizes
`define PAS_BUF_BYTES 16384
`define PAS_HDR_BYTES 16
`define PAS_DATA_BYTES 20
`define PAS_CPL_RATIO 4
`define PAS_MIN_RH 1
`define PAS_MIN_RD 16
`define PAS_LOW_RH 16
`define PAS_LOW_RD 32
`define PAS_BAL_RH 64
`define PAS_BAL_RD 153
`define PAS_CRED_W 12

// ==========================================
// Reset, config space, credit units
`define PAS_RST_HOLD 16
`define PAS_CFG_WORDS 16
`define PAS_CFG_AW 4
`define PAS_CRED_BYTES 16

// ==========================================
// Controller register offsets (bytes)
`define PAS_REG_CTRL 8'h00
`define PAS_REG_STAT 8'h04
`define PAS_REG_CRED 8'h08
`define PAS_REG_TXD 8'h0C
`define PAS_REG_MADDR 8'h10
`define PAS_REG_MDATA 8'h14
`define PAS_REG_MCMD 8'h18
`define PAS_REG_RXD 8'h1C
`define PAS_REG_CONS 8'h20

// ==========================================
// Field positions and transmit FIFO depth
`define PAS_CTRL_SEL 2
`define PAS_STAT_RST 0
`define PAS_STAT_TXE 1
`define PAS_STAT_RXE 2
`define PAS_STAT_BUSY 3
`define PAS_FIFO_DEPTH 32

`endif

/* inc/pas_pkg.sv */
/*
 * Types and parity helper shared by both ends.
 * Assumes pas_params.svh is on the include path.
 */
`default_nettype none
package pas_pkg;
    typedef enum logic [1:0] {
        PAS_ALLOC_MIN = 2'b00,
        PAS_ALLOC_LOW = 2'b01,
        PAS_ALLOC_BAL = 2'b10
    } pas_alloc_t;

    typedef enum logic [1:0] {
        PAS_M_IDLE = 2'b00,
        PAS_M_RD = 2'b01,
        PAS_M_WR = 2'b10
    } pas_mgmt_t;

    // Odd parity: each bit makes its byte plus parity hold an odd count of ones
    function automatic logic [31:0] pas_par_f(input logic [255:0] d);
        logic [31:0] p;
        p = 32'h0;
        for (int i = 0; i < 32; i++) begin
            p[i] = ~^d[8*i +: 8];
        end
        return p;
    endfunction : pas_par_f
endpackage : pas_pkg
`default_nettype wire

/* sim/pas_checker.sv */
/* Assertions on the link signals between both ends.
   Assumes the bench hands over the interface signals, one clock. */
`default_nettype none
module pas_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic reset_status,
    input wire logic stream_reset,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic [255:0] rx_data,
    input wire logic [31:0] rx_par,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [255:0] tx_data,
    input wire logic [31:0] tx_par,
    input wire logic [1:0] tx_sop,
    input wire logic [1:0] tx_eop
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [31:0] rx_ok;
    logic [31:0] tx_ok;
    // ==========================================
    // Odd parity, byte plus its bit
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            rx_ok[i] = ^{rx_data[8*i +: 8], rx_par[i]};
            tx_ok[i] = ^{tx_data[8*i +: 8], tx_par[i]};
        end
    end
    sequence held_s;
        reset_status [*8];
    endsequence
    rst_mirror_a: assert property (stream_reset == reset_status)
        else $error("stream reset differs");
    rst_hold_a: assert property ($rose(presetn) |-> held_s)
        else $error("reset status fell early");
    rdy_gate_a: assert property (reset_status |-> !tx_ready && !rx_ready)
        else $error("ready during reset");
    rx_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
        else $error("rx beat dropped");
    // Taken beat leaves the one-entry stage empty for a cycle
    rx_once_a: assert property (rx_valid && rx_ready |=> !rx_valid)
        else $error("rx beat repeated");
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("tx beat dropped");
    sop_pair_a: assert property (tx_valid |-> tx_sop == 2'h3 && tx_eop == 2'h3)
        else $error("tx flags wrong");
    rx_par_a: assert property (rx_valid |-> &rx_ok)
        else $error("rx parity not odd");
    tx_par_a: assert property (tx_valid |-> &tx_ok)
        else $error("tx parity not odd");
endmodule : pas_checker
`default_nettype wire

/* sim/pcie_app_stream_options_tb.sv */
/* Bench joining both ends, driven over APB and the link pins.
   Assumes package, interface, design and checker compiled first. */
`include "pas_params.svh"
`default_nettype none
module pcie_app_stream_options_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q, link_cfg_wdata = 32'h0, link_cfg_rsp_data;
    logic link_rx_valid = 0, link_tx_ready = 0, link_cfg_valid = 0, link_cfg_wr = 0;
    logic link_rx_ready, link_tx_valid, link_tx_err, link_cfg_rsp_valid;
    logic [255:0] link_rx_data = 256'h0, link_tx_data;
    logic [1:0] link_rx_sop = 2'h0, link_rx_eop = 2'h0, link_tx_sop, link_tx_eop;
    logic [3:0] link_cfg_addr = 4'h0;
    logic [31:0] cred [3] = '{32'h000A328F, 32'h00098260, 32'h00055156};
    int err_total = 0, checked = 0, cyc = 0;
    pas_if s_if ();
    always #5 pclk = ~pclk;
    pas_dev pas_dev_i (.pclk, .presetn, .s(s_if), .link_rx_valid, .link_rx_ready, .link_rx_data, .link_rx_sop,
        .link_rx_eop, .link_tx_valid, .link_tx_ready, .link_tx_data, .link_tx_sop, .link_tx_eop, .link_tx_err,
        .link_cfg_valid, .link_cfg_wr, .link_cfg_addr, .link_cfg_wdata, .link_cfg_rsp_valid, .link_cfg_rsp_data);
    pas_app pas_app_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .s(s_if));
    pas_checker pas_checker_i (.pclk, .presetn, .reset_status(s_if.reset_status),
        .stream_reset(s_if.stream_reset), .rx_valid(s_if.rx_valid), .rx_ready(s_if.rx_ready),
        .rx_data(s_if.rx_data), .rx_par(s_if.rx_par), .tx_valid(s_if.tx_valid), .tx_ready(s_if.tx_ready),
        .tx_data(s_if.tx_data), .tx_par(s_if.tx_par), .tx_sop(s_if.tx_sop), .tx_eop(s_if.tx_eop));
    // ==========================================
    // Bus and link tasks
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checked++;
        if (g !== x) begin
            err_total++;
            $display("ERROR %0t: got %h, expected %h", $time, g, x);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q, x);
    endtask : rd
    task automatic cfg(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge pclk);
        link_cfg_valid <= 1'b1;
        link_cfg_wr <= w;
        link_cfg_addr <= a;
        link_cfg_wdata <= d;
        @(posedge pclk);
        link_cfg_valid <= 1'b0;
        do @(posedge pclk); while (link_cfg_rsp_valid !== 1'b1);
        q = link_cfg_rsp_data;
    endtask : cfg
    task automatic finish_test;
        $display("checks %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test
    // Whole run is a few hundred cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            finish_test();
        end
    end
    // ==========================================
    // Tests
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(`PAS_REG_STAT, 32'h1);
        repeat (20) @(posedge pclk);
        rd(`PAS_REG_STAT, 32'h0);
        $display("reset test done");
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, `PAS_REG_CTRL, 32'(i));
            rd(`PAS_REG_CRED, cred[i]);
        end
        $display("credit test done");
        // Link stalls while two beats queue up
        for (int i = 0; i < 16; i++)
            apb(1'b1, `PAS_REG_TXD, 32'h11110000 + 32'(i));
        link_tx_ready <= 1'b1;
        for (int b = 0; b < 2; b++) begin
            do @(posedge pclk); while (link_tx_valid !== 1'b1);
            chk(link_tx_data[31:0], 32'h11110000 + 32'(8 * b));
            chk({27'h0, link_tx_sop, link_tx_eop, link_tx_err}, 32'h1E);
        end
        rd(`PAS_REG_CONS, 32'h4);
        $display("transmit test done");
        @(posedge pclk);
        link_rx_valid <= 1'b1;
        link_rx_data <= {8{32'hC3A50F71}};
        link_rx_sop <= 2'h3;
        link_rx_eop <= 2'h3;
        do @(posedge pclk); while (link_rx_ready !== 1'b1);
        link_rx_valid <= 1'b0;
        link_rx_data <= ~link_rx_data;
        rd(`PAS_REG_RXD, 32'hC3A50F71);
        rd(`PAS_REG_STAT, 32'h0);
        $display("receive test done");
        cfg(1'b1, 4'h3, 32'h5A5A0003);
        apb(1'b1, `PAS_REG_MADDR, 32'h3);
        apb(1'b1, `PAS_REG_MCMD, 32'h1);
        repeat (4) @(posedge pclk);
        rd(`PAS_REG_MDATA, 32'h5A5A0003);
        apb(1'b1, `PAS_REG_MADDR, 32'h5);
        apb(1'b1, `PAS_REG_MDATA, 32'h0000BEEF);
        apb(1'b1, `PAS_REG_MCMD, 32'h2);
        repeat (4) @(posedge pclk);
        cfg(1'b0, 4'h5, 32'h0);
        chk(q, 32'h0000BEEF);
        apb(1'b0, 8'h24, 32'h0);
        chk({q[30:0], e}, 32'h1);
        $display("management test done");
        finish_test();
    end
endmodule : pcie_app_stream_options_tb
`default_nettype wire
